// ===== ffd_fault_line.sv
/* Wired fault line with a pull-up.
   Assumes open-drain parties that only pull low. */
`timescale 1ns/1ps
`default_nettype none
module ffd_fault_line (
    // Pull requests.
    input wire logic i_dev_oe,
    input wire logic i_ext_pull,
    // Resolved level.
    output logic o_line_n
);
    // Any party pulling wins, else the pull-up holds the line high.
    assign o_line_n = !(i_dev_oe || i_ext_pull);
endmodule
`default_nettype wire

// ===== ffd_fault_monitor.sv
/* Port checks of the diagnostics bank.
   Assumes a bind onto ffd_top, one clock. */
`timescale 1ns/1ps
`default_nettype none
`include "ffd_map.svh"
module ffd_fault_monitor #(
    parameter int DATA_W = 24
) (
    // Clock and reset.
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    // Bus.
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] o_prdata,
    input wire logic o_pslverr,
    // Front end and converter.
    input wire ffd_pkg::ffd_detect_t i_detect,
    input wire logic i_conv_result_valid,
    input wire logic [DATA_W-1:0] i_conv_result,
    input wire logic i_conv_overrange,
    input wire ffd_pkg::ffd_afe_ctrl_t o_afe_ctrl,
    input wire logic [DATA_W-1:0] o_conv_data,
    // Fault pin.
    input wire logic o_fault_n,
    input wire logic o_fault_oe
);
    // All checks run on the system clock outside reset.
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    a_unmapped_error: assert property (
        i_psel && i_penable && i_paddr[7:2] == 6'h01 |->
        o_pslverr && o_prdata == 32'h0000_0000) else $error("unmapped");
    a_pin_only_low: assert property (
        o_fault_n == 1'b0) else $error("pin drives high");
    a_shut_pin: assert property (
        i_detect.heat_shutdown |-> o_fault_oe) else $error("pin idle");
    a_shut_ctrl: assert property (
        {4{i_detect.heat_shutdown}} == o_afe_ctrl[7:4]) else $error("ctrl");
    a_shut_wires: assert property (
        i_detect.heat_shutdown |-> o_afe_ctrl[3:0] == 4'h0)
        else $error("wire current on");
    a_full_scale: assert property (
        i_conv_result_valid && i_conv_overrange |=>
        o_conv_data == `FFD_FULL_SCALE) else $error("no full scale");
    a_result_load: assert property (
        i_conv_result_valid && !i_conv_overrange |=>
        o_conv_data == $past(i_conv_result)) else $error("load");
    a_data_hold: assert property (
        !i_conv_result_valid |=> $stable(o_conv_data)) else $error("hold");
endmodule
bind ffd_top ffd_fault_monitor #(.DATA_W(DATA_W)) u_ffd_fault_monitor (
    .i_sys_clk, .i_sys_rst, .i_psel, .i_penable, .i_paddr, .o_prdata,
    .o_pslverr, .i_detect, .i_conv_result_valid, .i_conv_result,
    .i_conv_overrange, .o_afe_ctrl, .o_conv_data, .o_fault_n, .o_fault_oe
);
`default_nettype wire

// ===== ffd_map.svh
/*
 * Register offsets, field positions and reset values of the front-end
 * fault diagnostics register bank.
 * Assumes inclusion by bare name from any design file.
 */
`ifndef FFD_MAP_SVH
`define FFD_MAP_SVH

// Word indexes; the byte address is four times the index.
`define FFD_IDX_SUMMARY 4'h0
`define FFD_IDX_MASK 4'h6
`define FFD_IDX_DETAIL 4'h7
`define FFD_IDX_OWIRE 4'h8
`define FFD_IDX_CONV_CFG 4'h9
`define FFD_IDX_CONV_STAT 4'hA
`define FFD_IDX_IRQ_STAT 4'hB
`define FFD_IDX_IRQ_EN 4'hC
`define FFD_IDX_IRQ_CLR 4'hD

// Summary status fields.
`define FFD_SUM_FAULT 0
`define FFD_SUM_HOT 2
`define FFD_SUM_SHUT 3
`define FFD_SUM_CRC 4
`define FFD_SUM_CHAN 5

// Detail status and mask fields.
`define FFD_DET_INOC 1
`define FFD_DET_LOOPOC 2
`define FFD_DET_ICOM 6
`define FFD_DET_IEXC 7
`define FFD_DET_PO 8
`define FFD_DET_NO 9
`define FFD_DET_PU 10
`define FFD_DET_NU 11
`define FFD_DET_ERR_MASK 16'h0FC6

// Reset values.
`define FFD_MASK_RST 16'h0000
`define FFD_OWIRE_RST 16'h0000
`define FFD_CONV_CFG_RST 16'h0000

// Converter fault-routing codes.
`define FFD_ROUTE_DRIVE 2'b10
`define FFD_ROUTE_INPUT 2'b01

// Converter full-scale positive code.
`define FFD_FULL_SCALE 24'hFF_FFFF
`endif

// ===== ffd_pkg.sv
/*
 * Types shared by the front-end fault diagnostics block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package ffd_pkg;
    // Raw analog detector levels, synchronous to the system clock.
    typedef struct packed {
        logic pos_input_over;
        logic neg_input_over;
        logic pos_input_under;
        logic neg_input_under;
        logic input_overcurrent;
        logic loop_supply_overcurrent;
        logic excitation_compliance_flag;
        logic compensation_compliance_flag;
        logic overheat;
        logic heat_shutdown;
        logic checksum_fault_flag;
        logic channel_fault_flag;
    } ffd_detect_t;

    // Controls handed to the analog front end.
    typedef struct packed {
        logic force_voltage_mode;
        logic sources_off;
        logic field_supply_off;
        logic amp_partial_off;
        logic [1:0] pos_wire_current;
        logic [1:0] neg_wire_current;
    } ffd_afe_ctrl_t;
endpackage

// ===== ffd_sticky.sv
/*
 * One bank of sticky flags: set by a level, cleared by a strobe.
 * Assumes set and clear are synchronous to the clock.
 */
`timescale 1ns/1ps
`default_nettype none
module ffd_sticky #(
    parameter int WIDTH = 2
) (
    // Clock and reset.
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    // Set and clear controls.
    input wire logic [WIDTH-1:0] i_set,
    input wire logic [WIDTH-1:0] i_clr,
    // Flag state.
    output logic [WIDTH-1:0] o_flag
);
    // A set in the clearing cycle wins so no event is lost.
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_flag <= '0;
        end else begin
            o_flag <= (o_flag & ~i_clr) | i_set;
        end
    end
endmodule
`default_nettype wire

// ===== ffd_tb.sv
/* Self-checking bench of the diagnostics bank.
   Assumes ffd_top, ffd_fault_line and the bound monitor. */
`timescale 1ns/1ps
`default_nettype none
`include "ffd_map.svh"
module testbench;
    logic i_sys_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_psel = 1'b0;
    logic i_penable = 1'b0;
    logic i_pwrite = 1'b0;
    logic [7:0] i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0000_0000;
    logic [31:0] o_prdata;
    logic o_pready, o_pslverr, o_fault_n, o_fault_oe, o_irq, line_n;
    logic ext_pull = 1'b0;
    ffd_pkg::ffd_detect_t i_detect = '0;
    ffd_pkg::ffd_afe_ctrl_t o_afe_ctrl;
    logic [3:0] i_conv_errors = 4'h0;
    logic i_conv_result_valid = 1'b0;
    logic i_conv_overrange = 1'b0;
    logic [23:0] i_conv_result = 24'h00_0000;
    logic [23:0] o_conv_data;
    logic [32:0] exp_q[$];
    logic [23:0] rnd;
    int err_count = 0;
    int num_checks = 0;
    // Design, wired fault line and clock.
    ffd_top u_ffd_top (.i_sys_clk, .i_sys_rst, .i_psel, .i_penable,
        .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
        .i_detect, .i_conv_errors, .i_conv_result_valid, .i_conv_result,
        .i_conv_overrange, .o_afe_ctrl, .o_conv_data, .i_fault_n(line_n),
        .o_fault_n, .o_fault_oe, .o_irq);
    ffd_fault_line u_ffd_fault_line (.i_dev_oe(o_fault_oe),
        .i_ext_pull(ext_pull), .o_line_n(line_n));
    always #2.5 i_sys_clk = ~i_sys_clk;
    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Compares one result.
    task automatic check(string what, logic [32:0] e, logic [32:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask
    // One APB transfer, held until ready is seen high.
    task automatic apb(logic wr, logic [5:0] idx, logic [31:0] wd);
        int n;
        @(posedge i_sys_clk);
        i_psel <= 1'b1;
        i_pwrite <= wr;
        i_paddr <= {idx, 2'b00};
        i_pwdata <= wd;
        @(posedge i_sys_clk);
        i_penable <= 1'b1;
        n = 0;
        do begin
            @(posedge i_sys_clk);
            n++;
        end while (o_pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_count++;
            give_verdict();
        end
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask
    // Notes the expected word, then reads.
    task automatic rd(logic [5:0] idx, logic [32:0] e);
        exp_q.push_back(e);
        apb(1'b0, idx, 32'h0000_0000);
    endtask
    // Waits n edges and lets their updates land.
    task automatic tick(int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask
    // Detector levels change at a rising edge.
    task automatic det(logic [11:0] v);
        @(posedge i_sys_clk);
        i_detect <= v;
    endtask
    // Takes the oldest note at each completed read.
    always @(posedge i_sys_clk) begin
        if (i_psel && i_penable && o_pready && !i_pwrite) begin
            if (exp_q.size() == 0) begin
                check("unexpected read", 33'h0, 33'h1_FFFF_FFFF);
            end else begin
                check("prdata", exp_q.pop_front(), {o_pslverr, o_prdata});
            end
        end
    end
    // Main sequence.
    initial begin
        void'($urandom(32'he800));
        repeat (2) @(posedge i_sys_clk);
        i_sys_rst <= 1'b0;
        rd(`FFD_IDX_MASK, 33'h0);
        rd(`FFD_IDX_OWIRE, 33'h0);
        rd(6'h01, {1'b1, 32'h0});
        $display("test reset done");
        for (int k = 0; k < 4; k++) begin
            det(12'h800 >> k);
            rd(`FFD_IDX_DETAIL, (16'h0100 << k) | 16'h0001);
            rd(`FFD_IDX_SUMMARY, 33'h1);
            tick(0);
            check("fault_oe", 1, o_fault_oe);
        end
        det(12'hF00);
        apb(1'b1, `FFD_IDX_MASK, 32'h0F00);
        rd(`FFD_IDX_DETAIL, 33'h0);
        rd(`FFD_IDX_SUMMARY, 33'h0);
        check("masked oe", 0, o_fault_oe);
        apb(1'b1, `FFD_IDX_MASK, 32'h0);
        rd(`FFD_IDX_DETAIL, 33'h0F01);
        $display("test flags done");
        det(12'h008);
        det(12'h000);
        rd(`FFD_IDX_SUMMARY, 33'h4);
        rd(`FFD_IDX_SUMMARY, 33'h0);
        det(12'h004);
        tick(2);
        check("afe shut", 8'hF0, o_afe_ctrl);
        det(12'h000);
        tick(2);
        check("afe cool", 8'h00, o_afe_ctrl);
        rd(`FFD_IDX_SUMMARY, 33'h8);
        rd(`FFD_IDX_SUMMARY, 33'h0);
        det(12'h0F3);
        rd(`FFD_IDX_DETAIL, 33'h00C7);
        rd(`FFD_IDX_SUMMARY, 33'h0031);
        check("flag oe", 1, o_fault_oe);
        det(12'h000);
        $display("test thermal done");
        rnd = 24'($urandom);
        apb(1'b1, `FFD_IDX_OWIRE, {28'h0, rnd[3:0]});
        rd(`FFD_IDX_OWIRE, {29'h0, rnd[3:0]});
        check("wire current", {rnd[1:0], rnd[3:2]}, o_afe_ctrl);
        apb(1'b1, `FFD_IDX_OWIRE, 32'h0);
        $display("test wire done");
        apb(1'b1, `FFD_IDX_CONV_CFG, 32'h2);
        i_conv_errors <= 4'h5;
        tick(2);
        check("conv oe", 1, o_fault_oe);
        apb(1'b1, `FFD_IDX_CONV_CFG, 32'h0);
        tick(2);
        check("route off oe", 0, o_fault_oe);
        apb(1'b1, `FFD_IDX_CONV_CFG, 32'h1);
        i_conv_errors <= 4'h0;
        ext_pull <= 1'b1;
        repeat (20) @(posedge i_sys_clk);
        i_conv_result_valid <= 1'b1;
        i_conv_result <= rnd;
        @(posedge i_sys_clk);
        i_conv_result_valid <= 1'b0;
        repeat (20) @(posedge i_sys_clk);
        ext_pull <= 1'b0;
        tick(0);
        check("conv data", rnd, o_conv_data);
        rd(`FFD_IDX_CONV_STAT, 33'h1);
        i_conv_result_valid <= 1'b1;
        i_conv_overrange <= 1'b1;
        @(posedge i_sys_clk);
        i_conv_result_valid <= 1'b0;
        tick(1);
        rd(`FFD_IDX_CONV_STAT, 33'h0);
        check("full scale", 24'hFF_FFFF, o_conv_data);
        $display("test converter done");
        apb(1'b1, `FFD_IDX_IRQ_CLR, 32'hF);
        apb(1'b1, `FFD_IDX_IRQ_EN, 32'h1);
        det(12'h400);
        det(12'h000);
        tick(2);
        check("irq sticky", 1, o_irq);
        apb(1'b1, `FFD_IDX_IRQ_CLR, 32'h1);
        tick(1);
        check("irq clear", 0, o_irq);
        apb(1'b1, `FFD_IDX_IRQ_EN, 32'h0);
        det(12'h400);
        tick(2);
        check("irq masked", 0, o_irq);
        det(12'h000);
        rd(`FFD_IDX_IRQ_STAT, 33'h9);
        rd(`FFD_IDX_IRQ_CLR, 33'h0);
        tick(2);
        $display("test irq done");
        check("queue left", 0, exp_q.size());
        give_verdict();
    end
endmodule
`default_nettype wire

// ===== ffd_top.sv
/*
 * Front-end fault diagnostics register bank with APB slave, fault pin
 * and converter fault routing.
 * Assumes an APB master on the system clock and detector inputs that are
 * already synchronous to that clock.
 */
// What this block does
// - Expose all flags in status registers (masked detail flags read as 0 in the detail register)
// - Fault pin is open-drain, active low
// - OR front-end errors, invert, drive pin
// - Route code 10: converter drives pin
// - Route code 01: pin ORed into status
// - Pin sampled unlatched, updated per result
// - Overheat flag bit 2, cleared on read
// - Shutdown forces safe mode, bit 3 latched
// - Cooling clears summary bit 0, restores functions
// - Over/under flags in detail bits 11:8
// - Any detail error sets summary bit 0
// - Flags enabled at reset, mask suppresses
// - Field supply may raise two flags
// - Open-wire currents off at reset, programmable
// - Open wire shows as over/under flag
// - Overrange gives full scale, no flag
`timescale 1ns/1ps
`default_nettype none
`include "ffd_map.svh"
module ffd_top #(
    parameter int DATA_W = 24
) (
    // Clock and reset.
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    // APB slave.
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Analog detectors and converter.
    input wire ffd_pkg::ffd_detect_t i_detect,
    input wire logic [3:0] i_conv_errors,
    input wire logic i_conv_result_valid,
    input wire logic [DATA_W-1:0] i_conv_result,
    input wire logic i_conv_overrange,
    // Front-end controls and converter data out.
    output ffd_pkg::ffd_afe_ctrl_t o_afe_ctrl,
    output logic [DATA_W-1:0] o_conv_data,
    // Open-drain fault pin.
    input wire logic i_fault_n,
    output logic o_fault_n,
    output logic o_fault_oe,
    // Interrupt.
    output logic o_irq
);
    logic [15:0] mask_reg;
    logic [15:0] owire_reg;
    logic [1:0] route_reg;
    logic conv_fault_reg;
    logic [3:0] conv_err_reg;
    logic [1:0] temp_latch;
    logic [3:0] irq_stat;
    logic [3:0] irq_en_reg;
    logic [3:0] irq_clr;
    logic [3:0] irq_set;
    logic [15:0] detail_raw;
    logic [15:0] detail_view;
    logic [15:0] summary_view;
    logic fe_fault;
    logic conv_any;
    logic acc;
    logic wr;
    logic rd;
    logic [5:0] idx;
    logic rd_summary;
    logic mapped;
    logic fault_prev;

    // Transfer decode: every access completes in its first access cycle.
    assign acc = i_psel & i_penable;
    assign wr = acc & i_pwrite;
    assign rd = acc & ~i_pwrite;
    assign idx = i_paddr[7:2];
    assign o_pready = 1'b1;
    assign rd_summary = rd && idx == {2'b00, `FFD_IDX_SUMMARY};

    // Raw detail flags in their register positions.
    always_comb begin
        detail_raw = 16'h0000;
        detail_raw[`FFD_DET_PO] = i_detect.pos_input_over;
        detail_raw[`FFD_DET_NO] = i_detect.neg_input_over;
        detail_raw[`FFD_DET_PU] = i_detect.pos_input_under;
        detail_raw[`FFD_DET_NU] = i_detect.neg_input_under;
        detail_raw[`FFD_DET_INOC] = i_detect.input_overcurrent;
        detail_raw[`FFD_DET_LOOPOC] = i_detect.loop_supply_overcurrent;
        detail_raw[`FFD_DET_IEXC] = i_detect.excitation_compliance_flag;
        detail_raw[`FFD_DET_ICOM] = i_detect.compensation_compliance_flag;
    end

    // Masked detail view; bit 0 summarises the remaining errors.
    always_comb begin
        detail_view = detail_raw & ~mask_reg & `FFD_DET_ERR_MASK;
        detail_view[0] = |detail_view;
    end

    // Latched temperature flags, cleared by a read of the summary.
    ffd_sticky #(
        .WIDTH(2)
    ) u_temp (
        .i_sys_clk(i_sys_clk),
        .i_sys_rst(i_sys_rst),
        .i_set({i_detect.heat_shutdown, i_detect.overheat}),
        .i_clr({2'b11} & {2{rd_summary}}),
        .o_flag(temp_latch)
    );

    // The summary fault bit follows live conditions, so cooling clears it.
    always_comb begin
        summary_view = 16'h0000;
        summary_view[`FFD_SUM_HOT] = temp_latch[0];
        summary_view[`FFD_SUM_SHUT] = temp_latch[1];
        summary_view[`FFD_SUM_CRC] = i_detect.checksum_fault_flag;
        summary_view[`FFD_SUM_CHAN] = i_detect.channel_fault_flag;
        summary_view[`FFD_SUM_FAULT] = detail_view[0]
            | i_detect.overheat | i_detect.heat_shutdown;
    end

    // Front-end fault is the OR of all error bits of both registers.
    assign fe_fault = |summary_view | detail_view[0];
    assign conv_any = |i_conv_errors;

    // Pin is pulled low only on an error, never driven high.
    always_comb begin
        o_fault_n = 1'b0;
        o_fault_oe = fe_fault;
        if (route_reg == `FFD_ROUTE_DRIVE && conv_any) begin
            o_fault_oe = 1'b1;
        end
    end

    // Shutdown puts the front end in its safe state while hot.
    always_comb begin
        o_afe_ctrl.force_voltage_mode = i_detect.heat_shutdown;
        o_afe_ctrl.sources_off = i_detect.heat_shutdown;
        o_afe_ctrl.field_supply_off = i_detect.heat_shutdown;
        o_afe_ctrl.amp_partial_off = i_detect.heat_shutdown;
        o_afe_ctrl.pos_wire_current = i_detect.heat_shutdown ? 2'b00
            : owire_reg[1:0];
        o_afe_ctrl.neg_wire_current = i_detect.heat_shutdown ? 2'b00
            : owire_reg[3:2];
    end

    // Software-written configuration registers.
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            mask_reg <= `FFD_MASK_RST;
            owire_reg <= `FFD_OWIRE_RST;
            route_reg <= 2'b00;
            irq_en_reg <= 4'h0;
        end else if (wr) begin
            if (idx == {2'b00, `FFD_IDX_MASK}) begin
                mask_reg <= i_pwdata[15:0] & `FFD_DET_ERR_MASK;
            end
            if (idx == {2'b00, `FFD_IDX_OWIRE}) begin
                owire_reg <= {12'h000, i_pwdata[3:0]};
            end
            if (idx == {2'b00, `FFD_IDX_CONV_CFG}) begin
                route_reg <= i_pwdata[1:0];
            end
            if (idx == {2'b00, `FFD_IDX_IRQ_EN}) begin
                irq_en_reg <= i_pwdata[3:0];
            end
        end
    end

    // Converter status is refreshed only when a result is written; the pin
    // is sampled in input mode with each result and held until the next one.
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            conv_fault_reg <= 1'b0;
            conv_err_reg <= 4'h0;
            o_conv_data <= '0;
        end else if (i_conv_result_valid) begin
            conv_err_reg <= i_conv_errors;
            conv_fault_reg <= conv_any | (route_reg == `FFD_ROUTE_INPUT
                && !i_fault_n);
            o_conv_data <= i_conv_overrange ? DATA_W'(`FFD_FULL_SCALE)
                : i_conv_result;
        end
    end

    // Interrupt events: summary fault level, shutdown, converter fault,
    // and the fault line falling.
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            fault_prev <= 1'b1;
        end else begin
            fault_prev <= i_fault_n;
        end
    end
    assign irq_set = {fault_prev & ~i_fault_n, conv_fault_reg,
        i_detect.heat_shutdown, summary_view[`FFD_SUM_FAULT]};
    assign irq_clr = (wr && idx == {2'b00, `FFD_IDX_IRQ_CLR}) ?
        i_pwdata[3:0] : 4'h0;

    ffd_sticky #(
        .WIDTH(4)
    ) u_irq (
        .i_sys_clk(i_sys_clk),
        .i_sys_rst(i_sys_rst),
        .i_set(irq_set),
        .i_clr(irq_clr),
        .o_flag(irq_stat)
    );

    assign o_irq = |(irq_stat & irq_en_reg);

    // Address map check for the error answer.
    always_comb begin
        unique case (idx)
            {2'b00, `FFD_IDX_SUMMARY}, {2'b00, `FFD_IDX_MASK},
            {2'b00, `FFD_IDX_DETAIL}, {2'b00, `FFD_IDX_OWIRE},
            {2'b00, `FFD_IDX_CONV_CFG}, {2'b00, `FFD_IDX_CONV_STAT},
            {2'b00, `FFD_IDX_IRQ_STAT}, {2'b00, `FFD_IDX_IRQ_EN},
            {2'b00, `FFD_IDX_IRQ_CLR}: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end
    assign o_pslverr = acc & ~mapped;

    // Read data mux; all status is readable here.
    always_comb begin
        o_prdata = 32'h0000_0000;
        if (rd) begin
            unique case (idx)
                {2'b00, `FFD_IDX_SUMMARY}: o_prdata[15:0] =
                    summary_view;
                {2'b00, `FFD_IDX_MASK}: o_prdata[15:0] = mask_reg;
                {2'b00, `FFD_IDX_DETAIL}: o_prdata[15:0] =
                    detail_view;
                {2'b00, `FFD_IDX_OWIRE}: o_prdata[15:0] = owire_reg;
                {2'b00, `FFD_IDX_CONV_CFG}: o_prdata[1:0] = route_reg;
                {2'b00, `FFD_IDX_CONV_STAT}: o_prdata[4:0] =
                    {conv_err_reg, conv_fault_reg};
                {2'b00, `FFD_IDX_IRQ_STAT}: o_prdata[3:0] = irq_stat;
                {2'b00, `FFD_IDX_IRQ_EN}: o_prdata[3:0] = irq_en_reg;
                default: o_prdata = 32'h0000_0000;
            endcase
        end
    end
endmodule
`default_nettype wire
